// File: common/serial_link_pkg.sv
// Shared constants, types and helpers for the host serial port and its host partner
package serial_link_pkg;
	localparam int CLK_HZ = 200_000_000;
	localparam int BAUD_DEFAULT = 9600;
	localparam int DATA_BITS = 8;
	localparam int CTS_HYSTERESIS = 16;
	localparam int TX_DEPTH = 8;
	localparam int RX_DEPTH = 64;
	localparam int STOP_THRESHOLD_DEFAULT = 48;
	localparam int CNT_W = 16;
	localparam logic LINE_IDLE = 1'b1;
	localparam logic START_LEVEL = 1'b0;
	localparam logic STOP_LEVEL = 1'b1;

	typedef enum logic [1:0] {UART_IDLE, UART_START, UART_DATA, UART_STOP} uart_state_type;

	// Clock cycles in one bit period
	function automatic int bitCycles(input int clkHz, input int baud);
		return clkHz / baud;
	endfunction
endpackage

// File: common/serial_link_if.sv
// Serial link wires between the radio module and its host
`timescale 1ns/10ps
`default_nettype none
interface serial_link_if;
	logic devTx;
	logic hostTx;
	logic ctsN;
	logic rtsN;
	modport device (output devTx, output ctsN, input hostTx, input rtsN);
	modport host (input devTx, input ctsN, output hostTx, output rtsN);
endinterface
`default_nettype wire

// File: rtl/host_serial_device.sv
// Module-side serial port: receive buffer, transmit buffer, UART and flow control
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = serial_link_pkg::TX_DEPTH
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady,
	output logic [$clog2(DEPTH):0] count
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
	logic [AW:0] count_r, count_nxt;
	logic doWrite, doRead;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign inReady = (count_r != (AW + 1)'(DEPTH));
	assign outValid = (count_r != '0);
	assign outData = mem[rdPtr_r];
	assign count = count_r;
	assign doWrite = inValid && inReady;
	assign doRead = outValid && outReady;

	always_comb begin
		wrPtr_nxt = doWrite ? bump(wrPtr_r) : wrPtr_r;
		rdPtr_nxt = doRead ? bump(rdPtr_r) : rdPtr_r;
		count_nxt = count_r;
		if (doWrite && !doRead) begin
			count_nxt = count_r + 1'b1;
		end else if (doRead && !doWrite) begin
			count_nxt = count_r - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else if (clkEn) begin
			wrPtr_r <= wrPtr_nxt;
			rdPtr_r <= rdPtr_nxt;
			count_r <= count_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (clkEn && doWrite) begin
			mem[wrPtr_r] <= inData;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Host holds serial input high when idle
// - Frame: low start, 8 data LSB first, high stop
// - Both ends share baud and format settings
// - Received characters wait in receive buffer
// - Radio packet bytes sent out in order
// - Drop whole packet when transmit space short
// - Hold receive drain during radio reception
// - Keep receive contents during routing delays
// - CTS pauses host; host obeys pause
// - RTS hold-off stops module transmission
// - CTS and RTS control enabled separately
// - CTS high at threshold, low below threshold-16
// - No transmission while RTS high, enabled
module host_serial_device #(
	parameter int BIT_CYCLES = serial_link_pkg::bitCycles(serial_link_pkg::CLK_HZ,
		serial_link_pkg::BAUD_DEFAULT),
	parameter int RX_DEPTH = serial_link_pkg::RX_DEPTH,
	parameter int TX_DEPTH = serial_link_pkg::TX_DEPTH
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	serial_link_if.device link,
	input wire logic rtsFlowEnable,
	input wire logic ctsFlowEnable,
	input wire logic [7:0] flowStopThreshold,
	input wire logic radioRxActive,
	input wire logic routeHold,
	output logic [7:0] rxData,
	output logic rxValid,
	input wire logic rxReady,
	output logic rxFrameErr,
	output logic rxOverrun,
	input wire logic [7:0] pktData,
	input wire logic pktValid,
	input wire logic pktFirst,
	input wire logic [7:0] pktLen,
	output logic pktReady,
	output logic pktDropped
);
	localparam int CW = serial_link_pkg::CNT_W;
	localparam logic [CW-1:0] FULL_BIT = CW'(BIT_CYCLES - 1);
	localparam logic [CW-1:0] HALF_BIT = CW'(BIT_CYCLES / 2 - 1);
	localparam logic [2:0] LAST_BIT = 3'(serial_link_pkg::DATA_BITS - 1);
	localparam logic [8:0] HYST = 9'(serial_link_pkg::CTS_HYSTERESIS);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic rxS1_r, rxS2_r, rxS3_r, rtsS1_r, rtsS2_r;
	always_ff @(posedge clk) begin
		if (reset) begin
			rxS1_r <= 1'b1;
			rxS2_r <= 1'b1;
			rxS3_r <= 1'b1;
			rtsS1_r <= 1'b0;
			rtsS2_r <= 1'b0;
		end else if (clkEn) begin
			rxS1_r <= link.hostTx;
			rxS2_r <= rxS1_r;
			rxS3_r <= rxS2_r;
			rtsS1_r <= link.rtsN;
			rtsS2_r <= rtsS1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receiver
	serial_link_pkg::uart_state_type rxSt_r, rxSt_nxt;
	logic [CW-1:0] rxCnt_r, rxCnt_nxt;
	logic [2:0] rxBit_r, rxBit_nxt;
	logic [7:0] rxShift_r, rxShift_nxt;
	logic rxPush, rxErr_nxt, rxFifoReady, rxOver_nxt;

	always_comb begin
		rxSt_nxt = rxSt_r;
		rxCnt_nxt = rxCnt_r;
		rxBit_nxt = rxBit_r;
		rxShift_nxt = rxShift_r;
		rxPush = 1'b0;
		rxErr_nxt = 1'b0;
		case (rxSt_r)
			serial_link_pkg::UART_IDLE: begin
				if (rxS3_r && !rxS2_r) begin
					rxSt_nxt = serial_link_pkg::UART_START;
					rxCnt_nxt = HALF_BIT;
				end
			end
			serial_link_pkg::UART_START: begin
				if (rxCnt_r != '0) begin
					rxCnt_nxt = rxCnt_r - 1'b1;
				end else if (rxS2_r == serial_link_pkg::START_LEVEL) begin
					rxSt_nxt = serial_link_pkg::UART_DATA;
					rxCnt_nxt = FULL_BIT;
					rxBit_nxt = '0;
				end else begin
					rxSt_nxt = serial_link_pkg::UART_IDLE;
				end
			end
			serial_link_pkg::UART_DATA: begin
				if (rxCnt_r != '0) begin
					rxCnt_nxt = rxCnt_r - 1'b1;
				end else begin
					rxShift_nxt = {rxS2_r, rxShift_r[7:1]};
					rxCnt_nxt = FULL_BIT;
					rxBit_nxt = rxBit_r + 1'b1;
					if (rxBit_r == LAST_BIT) begin
						rxSt_nxt = serial_link_pkg::UART_STOP;
					end
				end
			end
			default: begin
				if (rxCnt_r != '0) begin
					rxCnt_nxt = rxCnt_r - 1'b1;
				end else begin
					rxSt_nxt = serial_link_pkg::UART_IDLE;
					rxPush = (rxS2_r == serial_link_pkg::STOP_LEVEL);
					rxErr_nxt = (rxS2_r != serial_link_pkg::STOP_LEVEL);
				end
			end
		endcase
		rxOver_nxt = rxPush && !rxFifoReady;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rxSt_r <= serial_link_pkg::UART_IDLE;
			rxCnt_r <= '0;
			rxBit_r <= '0;
			rxShift_r <= '0;
			rxFrameErr <= 1'b0;
			rxOverrun <= 1'b0;
		end else if (clkEn) begin
			rxSt_r <= rxSt_nxt;
			rxCnt_r <= rxCnt_nxt;
			rxBit_r <= rxBit_nxt;
			rxShift_r <= rxShift_nxt;
			rxFrameErr <= rxErr_nxt;
			rxOverrun <= rxOver_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive buffer, drain stage and CTS
	logic [7:0] rxFifoData;
	logic rxFifoValid, rxPop, rxValid_nxt, ctsN_r, ctsN_nxt;
	logic [7:0] rxData_nxt;
	logic [$clog2(RX_DEPTH):0] rxCount;
	logic [8:0] occ;

	byte_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH)) rxBuf (
		.clk(clk), .reset(reset), .clkEn(clkEn),
		.inData(rxShift_r), .inValid(rxPush), .inReady(rxFifoReady),
		.outData(rxFifoData), .outValid(rxFifoValid), .outReady(rxPop),
		.count(rxCount)
	);

	always_comb begin
		rxPop = rxFifoValid && !radioRxActive && !routeHold && (!rxValid || rxReady);
		rxValid_nxt = rxPop ? 1'b1 : (rxReady ? 1'b0 : rxValid);
		rxData_nxt = rxPop ? rxFifoData : rxData;
		occ = 9'(rxCount);
		ctsN_nxt = ctsN_r;
		if (!ctsFlowEnable) begin
			ctsN_nxt = 1'b0;
		end else if (occ >= {1'b0, flowStopThreshold}) begin
			ctsN_nxt = 1'b1;
		end else if (occ + HYST < {1'b0, flowStopThreshold}) begin
			ctsN_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rxValid <= 1'b0;
			rxData <= '0;
			ctsN_r <= 1'b0;
		end else if (clkEn) begin
			rxValid <= rxValid_nxt;
			rxData <= rxData_nxt;
			ctsN_r <= ctsN_nxt;
		end
	end
	assign link.ctsN = ctsN_r;

	////////////////////////////////////////////////////////////////////////////
	// Transmit buffer with whole-packet drop
	logic dropping_r, dropping_nxt, dropNow, txFifoReady, txFifoValid, txPop, dropped_nxt;
	logic [7:0] txFifoData, freeSpace;
	logic [$clog2(TX_DEPTH):0] txCount;

	always_comb begin
		freeSpace = 8'(TX_DEPTH) - 8'(txCount);
		dropNow = pktFirst ? (pktLen > freeSpace) : dropping_r;
		dropping_nxt = (pktValid && pktFirst) ? dropNow : dropping_r;
		dropped_nxt = pktValid && pktFirst && dropNow;
		pktReady = dropNow ? 1'b1 : txFifoReady;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			dropping_r <= 1'b0;
			pktDropped <= 1'b0;
		end else if (clkEn) begin
			dropping_r <= dropping_nxt;
			pktDropped <= dropped_nxt;
		end
	end

	byte_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) txBuf (
		.clk(clk), .reset(reset), .clkEn(clkEn),
		.inData(pktData), .inValid(pktValid && !dropNow), .inReady(txFifoReady),
		.outData(txFifoData), .outValid(txFifoValid), .outReady(txPop),
		.count(txCount)
	);

	////////////////////////////////////////////////////////////////////////////
	// Transmitter
	serial_link_pkg::uart_state_type txSt_r, txSt_nxt;
	logic [CW-1:0] txCnt_r, txCnt_nxt;
	logic [2:0] txBit_r, txBit_nxt;
	logic [7:0] txShift_r, txShift_nxt;
	logic txLine_r, txLine_nxt;

	always_comb begin
		txSt_nxt = txSt_r;
		txCnt_nxt = txCnt_r;
		txBit_nxt = txBit_r;
		txShift_nxt = txShift_r;
		txLine_nxt = txLine_r;
		txPop = 1'b0;
		case (txSt_r)
			serial_link_pkg::UART_IDLE: begin
				if (txFifoValid && !(rtsFlowEnable && rtsS2_r)) begin
					txPop = 1'b1;
					txShift_nxt = txFifoData;
					txLine_nxt = serial_link_pkg::START_LEVEL;
					txCnt_nxt = FULL_BIT;
					txSt_nxt = serial_link_pkg::UART_START;
				end
			end
			serial_link_pkg::UART_START: begin
				if (txCnt_r != '0) begin
					txCnt_nxt = txCnt_r - 1'b1;
				end else begin
					txLine_nxt = txShift_r[0];
					txBit_nxt = '0;
					txCnt_nxt = FULL_BIT;
					txSt_nxt = serial_link_pkg::UART_DATA;
				end
			end
			serial_link_pkg::UART_DATA: begin
				if (txCnt_r != '0) begin
					txCnt_nxt = txCnt_r - 1'b1;
				end else begin
					txShift_nxt = {1'b0, txShift_r[7:1]};
					txBit_nxt = txBit_r + 1'b1;
					txCnt_nxt = FULL_BIT;
					if (txBit_r == LAST_BIT) begin
						txLine_nxt = serial_link_pkg::STOP_LEVEL;
						txSt_nxt = serial_link_pkg::UART_STOP;
					end else begin
						txLine_nxt = txShift_r[1];
					end
				end
			end
			default: begin
				if (txCnt_r != '0) begin
					txCnt_nxt = txCnt_r - 1'b1;
				end else begin
					txSt_nxt = serial_link_pkg::UART_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			txSt_r <= serial_link_pkg::UART_IDLE;
			txCnt_r <= '0;
			txBit_r <= '0;
			txShift_r <= '0;
			txLine_r <= serial_link_pkg::LINE_IDLE;
		end else if (clkEn) begin
			txSt_r <= txSt_nxt;
			txCnt_r <= txCnt_nxt;
			txBit_r <= txBit_nxt;
			txShift_r <= txShift_nxt;
			txLine_r <= txLine_nxt;
		end
	end
	assign link.devTx = txLine_r;
endmodule
`default_nettype wire

// File: rtl/host_serial_host.sv
// Host-side UART partner that obeys and drives serial flow control
`timescale 1ns/10ps
`default_nettype none
module host_serial_host #(
	parameter int BIT_CYCLES = serial_link_pkg::bitCycles(serial_link_pkg::CLK_HZ,
		serial_link_pkg::BAUD_DEFAULT)
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	serial_link_if.host link,
	input wire logic holdOff,
	input wire logic [7:0] sendData,
	input wire logic sendValid,
	output logic sendReady,
	output logic [7:0] recvData,
	output logic recvValid,
	output logic recvFrameErr
);
	localparam int CW = serial_link_pkg::CNT_W;
	localparam logic [CW-1:0] FULL_BIT = CW'(BIT_CYCLES - 1);
	localparam logic [CW-1:0] HALF_BIT = CW'(BIT_CYCLES / 2 - 1);
	localparam logic [3:0] FRAME_BITS = 4'(serial_link_pkg::DATA_BITS + 1);
	localparam logic [3:0] LAST_RX = 4'(serial_link_pkg::DATA_BITS);

	////////////////////////////////////////////////////////////////////////////
	// Synchronisers and RTS
	logic inS1_r, inS2_r, inS3_r, ctsS1_r, ctsS2_r, rtsN_r;
	always_ff @(posedge clk) begin
		if (reset) begin
			inS1_r <= 1'b1;
			inS2_r <= 1'b1;
			inS3_r <= 1'b1;
			ctsS1_r <= 1'b0;
			ctsS2_r <= 1'b0;
			rtsN_r <= 1'b0;
		end else if (clkEn) begin
			inS1_r <= link.devTx;
			inS2_r <= inS1_r;
			inS3_r <= inS2_r;
			ctsS1_r <= link.ctsN;
			ctsS2_r <= ctsS1_r;
			rtsN_r <= holdOff;
		end
	end
	assign link.rtsN = rtsN_r;

	////////////////////////////////////////////////////////////////////////////
	// Transmitter: 10-bit frame shifted out LSB first
	logic busy_r, busy_nxt, line_r, line_nxt;
	logic [CW-1:0] txCnt_r, txCnt_nxt;
	logic [3:0] txLeft_r, txLeft_nxt;
	logic [8:0] txShift_r, txShift_nxt;

	assign sendReady = !busy_r && !ctsS2_r;

	always_comb begin
		busy_nxt = busy_r;
		line_nxt = line_r;
		txCnt_nxt = txCnt_r;
		txLeft_nxt = txLeft_r;
		txShift_nxt = txShift_r;
		if (!busy_r) begin
			line_nxt = serial_link_pkg::LINE_IDLE;
			if (sendValid && !ctsS2_r) begin
				busy_nxt = 1'b1;
				line_nxt = serial_link_pkg::START_LEVEL;
				txShift_nxt = {serial_link_pkg::STOP_LEVEL, sendData};
				txLeft_nxt = FRAME_BITS;
				txCnt_nxt = FULL_BIT;
			end
		end else if (txCnt_r != '0) begin
			txCnt_nxt = txCnt_r - 1'b1;
		end else if (txLeft_r == '0) begin
			busy_nxt = 1'b0;
		end else begin
			line_nxt = txShift_r[0];
			txShift_nxt = {1'b1, txShift_r[8:1]};
			txLeft_nxt = txLeft_r - 1'b1;
			txCnt_nxt = FULL_BIT;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			busy_r <= 1'b0;
			line_r <= serial_link_pkg::LINE_IDLE;
			txCnt_r <= '0;
			txLeft_r <= '0;
			txShift_r <= '0;
		end else if (clkEn) begin
			busy_r <= busy_nxt;
			line_r <= line_nxt;
			txCnt_r <= txCnt_nxt;
			txLeft_r <= txLeft_nxt;
			txShift_r <= txShift_nxt;
		end
	end
	assign link.hostTx = line_r;

	////////////////////////////////////////////////////////////////////////////
	// Receiver
	logic rxBusy_r, rxBusy_nxt, valid_nxt, err_nxt;
	logic [CW-1:0] rxCnt_r, rxCnt_nxt;
	logic [3:0] rxIdx_r, rxIdx_nxt;
	logic [7:0] rxShift_r, rxShift_nxt, data_nxt;

	always_comb begin
		rxBusy_nxt = rxBusy_r;
		rxCnt_nxt = rxCnt_r;
		rxIdx_nxt = rxIdx_r;
		rxShift_nxt = rxShift_r;
		data_nxt = recvData;
		valid_nxt = 1'b0;
		err_nxt = 1'b0;
		if (!rxBusy_r) begin
			if (inS3_r && !inS2_r) begin
				rxBusy_nxt = 1'b1;
				rxCnt_nxt = HALF_BIT;
				rxIdx_nxt = '0;
			end
		end else if (rxCnt_r != '0) begin
			rxCnt_nxt = rxCnt_r - 1'b1;
		end else if (rxIdx_r == '0) begin
			rxBusy_nxt = (inS2_r == serial_link_pkg::START_LEVEL);
			rxIdx_nxt = 4'd1;
			rxCnt_nxt = FULL_BIT;
		end else if (rxIdx_r <= LAST_RX) begin
			rxShift_nxt = {inS2_r, rxShift_r[7:1]};
			rxIdx_nxt = rxIdx_r + 1'b1;
			rxCnt_nxt = FULL_BIT;
		end else begin
			rxBusy_nxt = 1'b0;
			valid_nxt = (inS2_r == serial_link_pkg::STOP_LEVEL);
			err_nxt = (inS2_r != serial_link_pkg::STOP_LEVEL);
			data_nxt = valid_nxt ? rxShift_r : recvData;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rxBusy_r <= 1'b0;
			rxCnt_r <= '0;
			rxIdx_r <= '0;
			rxShift_r <= '0;
			recvData <= '0;
			recvValid <= 1'b0;
			recvFrameErr <= 1'b0;
		end else if (clkEn) begin
			rxBusy_r <= rxBusy_nxt;
			rxCnt_r <= rxCnt_nxt;
			rxIdx_r <= rxIdx_nxt;
			rxShift_r <= rxShift_nxt;
			recvData <= data_nxt;
			recvValid <= valid_nxt;
			recvFrameErr <= err_nxt;
		end
	end
endmodule
`default_nettype wire

// File: dv/host_serial_port_sva.sv
// Assertions on the serial link between the module and its host
`timescale 1ns/10ps
`default_nettype none
module host_serial_port_sva #(
	parameter int BIT_CYCLES = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic devTx,
	input wire logic hostTx,
	input wire logic ctsN,
	input wire logic rtsN,
	input wire logic rtsFlowEnable,
	input wire logic ctsFlowEnable
);
	// Frame position per line: index 0 module output, index 1 host output
	logic [1:0] line;
	logic [1:0] last_r;
	logic [1:0] startEv;
	int pos_r [2];
	int pos_nxt [2];
	assign line = {hostTx, devTx};
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			startEv[i] = (pos_r[i] == 0) && last_r[i] && !line[i];
			if (startEv[i]) begin
				pos_nxt[i] = 1;
			end else if (pos_r[i] != 0 && pos_r[i] < 10 * BIT_CYCLES - 1) begin
				pos_nxt[i] = pos_r[i] + 1;
			end else begin
				pos_nxt[i] = 0;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			last_r <= 2'h3;
			pos_r <= '{default: 0};
		end else begin
			last_r <= line;
			pos_r <= pos_nxt;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	a_reset_idle: assert property ($fell(reset) |-> devTx && hostTx && !ctsN && !rtsN)
		else $error("link not idle after reset");
	a_dev_start: assert property (pos_r[0] > 0 && pos_r[0] < BIT_CYCLES |-> !devTx)
		else $error("module start bit too short");
	a_dev_stop: assert property (pos_r[0] >= 9 * BIT_CYCLES |-> devTx)
		else $error("module stop bit low");
	a_host_start: assert property (pos_r[1] > 0 && pos_r[1] < BIT_CYCLES |-> !hostTx)
		else $error("host start bit too short");
	a_host_stop: assert property (pos_r[1] >= 9 * BIT_CYCLES |-> hostTx)
		else $error("host stop bit low");
	a_dev_bit_steady: assert property (pos_r[0] % BIT_CYCLES != 0 |-> $stable(devTx))
		else $error("module bit changed mid period");
	a_host_bit_steady: assert property (pos_r[1] % BIT_CYCLES != 0 |-> $stable(hostTx))
		else $error("host bit changed mid period");
	a_rts_hold: assert property ((rtsFlowEnable && rtsN) [*8] |-> !startEv[0])
		else $error("module started a character during hold-off");
	a_cts_obeyed: assert property (ctsN [*8] |-> !startEv[1])
		else $error("host started a character while paused");
	a_cts_off: assert property (!ctsFlowEnable [*3] |-> !ctsN)
		else $error("pause shown while disabled");
endmodule
`default_nettype wire

// File: dv/host_serial_port_buffers_test.sv
// Self-checking bench for the module serial port facing its host partner
`timescale 1ns/10ps
`default_nettype none
module host_serial_port_buffers_test;
	localparam int BIT = 16;
	localparam int LIMIT = 4000;
	typedef struct packed {logic toHost; logic [7:0] dat; logic [7:0] exp;} row_type;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic rtsFlowEnable = 1'b0, ctsFlowEnable = 1'b0, radioRxActive = 1'b0, routeHold = 1'b0;
	logic rxReady = 1'b0, pktValid = 1'b0, pktFirst = 1'b0, holdOff = 1'b0, sendValid = 1'b0;
	logic [7:0] flowStopThreshold = 8'h30, pktData = 8'h00, pktLen = 8'h00, sendData = 8'h00;
	logic [7:0] rxData, recvData;
	logic rxValid, rxFrameErr, rxOverrun, pktReady, pktDropped, sendReady, recvValid, recvFrameErr;
	int n_fail = 0;
	int checks_done = 0;
	int overruns = 0;
	int frameErrs = 0;
	int w;
	row_type rows [6] = '{{1'b1, 8'h1f, 8'h1f}, {1'b0, 8'h1f, 8'h1f}, {1'b1, 8'h00, 8'h00},
		{1'b0, 8'hff, 8'hff}, {1'b1, 8'ha5, 8'ha5}, {1'b0, 8'h80, 8'h80}};
	serial_link_if link();
	host_serial_device #(.BIT_CYCLES(BIT), .RX_DEPTH(64), .TX_DEPTH(8)) u_host_serial_device (
		.clk(clk), .reset(reset), .clkEn(1'b1), .link(link), .rtsFlowEnable(rtsFlowEnable),
		.ctsFlowEnable(ctsFlowEnable), .flowStopThreshold(flowStopThreshold),
		.radioRxActive(radioRxActive), .routeHold(routeHold), .rxData(rxData),
		.rxValid(rxValid), .rxReady(rxReady), .rxFrameErr(rxFrameErr), .rxOverrun(rxOverrun),
		.pktData(pktData), .pktValid(pktValid), .pktFirst(pktFirst), .pktLen(pktLen),
		.pktReady(pktReady), .pktDropped(pktDropped));
	host_serial_host #(.BIT_CYCLES(BIT)) u_host_serial_host (
		.clk(clk), .reset(reset), .clkEn(1'b1), .link(link), .holdOff(holdOff),
		.sendData(sendData), .sendValid(sendValid), .sendReady(sendReady),
		.recvData(recvData), .recvValid(recvValid), .recvFrameErr(recvFrameErr));
	host_serial_port_sva #(.BIT_CYCLES(BIT)) u_host_serial_port_sva (
		.clk(clk), .reset(reset), .devTx(link.devTx), .hostTx(link.hostTx), .ctsN(link.ctsN),
		.rtsN(link.rtsN), .rtsFlowEnable(rtsFlowEnable), .ctsFlowEnable(ctsFlowEnable));
	always #2.5 clk = ~clk;
	// Pulse counters for the receive error outputs
	always @(negedge clk) begin
		if (rxOverrun === 1'b1) overruns++;
		if (rxFrameErr === 1'b1) frameErrs++;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check1(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic expire(input string what);
		n_fail++;
		$display("wrong value %s expected handshake seen timeout", what);
		results();
	endtask
	task automatic hostSend(input logic [7:0] b);
		for (w = 0; w < LIMIT && sendReady !== 1'b1; w++) @(negedge clk);
		if (w == LIMIT) expire("sendReady");
		sendData = b;
		sendValid = 1'b1;
		@(negedge clk);
		sendValid = 1'b0;
	endtask
	task automatic popRx(input logic [7:0] exp);
		for (w = 0; w < LIMIT && rxValid !== 1'b1; w++) @(negedge clk);
		if (w == LIMIT) expire("rxValid");
		check8("rxData", exp, rxData);
		rxReady = 1'b1;
		@(negedge clk);
		rxReady = 1'b0;
	endtask
	task automatic hostRecv(input logic [7:0] exp);
		for (w = 0; w < LIMIT && recvValid !== 1'b1; w++) @(negedge clk);
		if (w == LIMIT) expire("recvValid");
		check8("recvData", exp, recvData);
		check1("recvFrameErr", 1'b0, recvFrameErr);
		@(negedge clk);
	endtask
	task automatic sendPkt(input logic [7:0] first, input int len, input logic expDrop);
		logic seen;
		seen = 1'b0;
		for (int i = 0; i < len; i++) begin
			pktData = first + 8'(i);
			pktValid = 1'b1;
			pktFirst = (i == 0);
			pktLen = 8'(len);
			check1("pktReady", 1'b1, pktReady);
			@(negedge clk);
			seen = seen | pktDropped;
		end
		pktValid = 1'b0;
		pktFirst = 1'b0;
		@(negedge clk);
		check1("pktDropped", expDrop, seen | pktDropped);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(negedge clk);
		reset = 1'b0;
		check1("hostTx", 1'b1, link.hostTx);
		check1("devTx", 1'b1, link.devTx);
		check1("ctsN", 1'b0, link.ctsN);
		foreach (rows[i]) begin
			if (rows[i].toHost) begin
				sendPkt(rows[i].dat, 1, 1'b0);
				hostRecv(rows[i].exp);
			end else begin
				hostSend(rows[i].dat);
				popRx(rows[i].exp);
			end
		end
		rtsFlowEnable = 1'b1;
		holdOff = 1'b1;
		repeat (4) @(negedge clk);
		sendPkt(8'h40, 5, 1'b0);
		sendPkt(8'h50, 4, 1'b1);
		sendPkt(8'h60, 3, 1'b0);
		repeat (12 * BIT) @(negedge clk);
		check1("recvValid", 1'b0, recvValid);
		check1("devTx", 1'b1, link.devTx);
		holdOff = 1'b0;
		for (int i = 0; i < 5; i++) hostRecv(8'h40 + 8'(i));
		for (int i = 0; i < 3; i++) hostRecv(8'h60 + 8'(i));
		rtsFlowEnable = 1'b0;
		holdOff = 1'b1;
		sendPkt(8'h70, 1, 1'b0);
		hostRecv(8'h70);
		holdOff = 1'b0;
		radioRxActive = 1'b1;
		hostSend(8'h81);
		hostSend(8'h82);
		repeat (12 * BIT) @(negedge clk);
		check1("rxValid", 1'b0, rxValid);
		radioRxActive = 1'b0;
		routeHold = 1'b1;
		repeat (4) @(negedge clk);
		check1("rxValid", 1'b0, rxValid);
		routeHold = 1'b0;
		popRx(8'h81);
		popRx(8'h82);
		ctsFlowEnable = 1'b1;
		flowStopThreshold = 8'h14;
		radioRxActive = 1'b1;
		for (int i = 0; i < 19; i++) hostSend(8'h30 + 8'(i));
		repeat (12 * BIT) @(negedge clk);
		check1("ctsN", 1'b0, link.ctsN);
		hostSend(8'h43);
		repeat (12 * BIT) @(negedge clk);
		check1("ctsN", 1'b1, link.ctsN);
		check1("sendReady", 1'b0, sendReady);
		radioRxActive = 1'b0;
		for (int i = 0; i < 16; i++) begin
			if (i == 15) check1("ctsN", 1'b1, link.ctsN);
			popRx(8'h30 + 8'(i));
		end
		repeat (4) @(negedge clk);
		check1("ctsN", 1'b0, link.ctsN);
		for (int i = 16; i < 20; i++) popRx(8'h30 + 8'(i));
		ctsFlowEnable = 1'b0;
		repeat (4) @(negedge clk);
		check1("ctsN", 1'b0, link.ctsN);
		radioRxActive = 1'b1;
		for (int i = 0; i < 65; i++) hostSend(8'(i));
		repeat (12 * BIT) @(negedge clk);
		check8("rxOverrun count", 8'h01, 8'(overruns));
		check8("rxFrameErr count", 8'h00, 8'(frameErrs));
		reset = 1'b1;
		repeat (2) @(negedge clk);
		reset = 1'b0;
		radioRxActive = 1'b0;
		check1("devTx", 1'b1, link.devTx);
		check1("ctsN", 1'b0, link.ctsN);
		repeat (4) @(negedge clk);
		check1("rxValid", 1'b0, rxValid);
		results();
	end
endmodule
`default_nettype wire
